// ---- rtl/hti_readout.sv ----
// Bus target, conversion timer and response frame of the sensor readout
// Overview of operation
// - First byte of every read is the status byte.
// - Humidity follows as a 20-bit unsigned sample.
// - Temperature follows humidity as a 20-bit unsigned sample.
// - Last byte is CRC8 over status, humidity and temperature.
// - Status bit 7 is 1 while converting, 0 when idle and asleep.
// - Status bits 6:5 give work mode: 00 normal, 01 cyclic, 1x host-directed.
// - CRC8 seed 0xff, polynomial x^8+x^5+x^4+1; host checks it.
// - After conversion the device sleeps until the next trigger sequence.
`timescale 1ns/100ps
`default_nettype none
module hti_readout #(
  parameter int CONV_CYC = hti_pkg::CONV_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Two-wire bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Measurement front end
  input wire logic [hti_pkg::SAMPLE_W-1:0] humidity_sample,
  input wire logic [hti_pkg::SAMPLE_W-1:0] temperature_sample,
  input wire logic [1:0] work_mode,
  output logic conv_start,
  output logic conv_busy
);
  import hti_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  // Third stage only remembers the previous settled level
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
    end else begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_i, scl_s1_q, scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_i, sda_s1_q, sda_s2_q};
    end
  end

  assign scl_rise = scl_s2_q & ~scl_s3_q;
  assign scl_fall = ~scl_s2_q & scl_s3_q;
  assign bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign bus_stop = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

  ////////////////////////////////////////////////////////////////////////
  // Conversion timer and result holding
  logic busy_q, busy_d, start_q, start_d;
  logic [CONV_CNT_W-1:0] ccnt_q, ccnt_d;
  logic [SAMPLE_W-1:0] hum_q, hum_d, temp_q, temp_d;

  // Results only move at the end of a conversion, so early reads see old data
  always_comb begin
    busy_d = busy_q;
    ccnt_d = ccnt_q;
    hum_d = hum_q;
    temp_d = temp_q;
    if (start_q && !busy_q) begin
      busy_d = 1'b1;
      ccnt_d = CONV_CNT_W'(CONV_CYC - 1);
    end else if (busy_q) begin
      if (ccnt_q == '0) begin
        busy_d = 1'b0;
        hum_d = humidity_sample;
        temp_d = temperature_sample;
      end else begin
        ccnt_d = ccnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      ccnt_q <= '0;
      hum_q <= '0;
      temp_q <= '0;
    end else begin
      busy_q <= busy_d;
      ccnt_q <= ccnt_d;
      hum_q <= hum_d;
      temp_q <= temp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus engine
  hti_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d;
  logic [2:0] idx_q, idx_d;
  logic [1:0] cmd_q, cmd_d;
  logic rd_q, rd_d, oe_q, oe_d;
  logic load;
  logic [2:0] load_idx;
  logic [7:0] byte_val, status_val, cmd_exp;
  hti_crc_if crc_bus ();

  hti_crc8 u_crc (
    .clk(clk),
    .resetn(resetn),
    .bus(crc_bus.calc)
  );

  // Status is sampled live when its byte is loaded
  assign status_val = {busy_q, work_mode, ST_LOW_RESET};

  // Frame byte selection, MSB first with a shared middle byte
  always_comb begin
    unique case (load_idx)
      3'h0: byte_val = status_val;
      3'h1: byte_val = hum_q[19:12];
      3'h2: byte_val = hum_q[11:4];
      3'h3: byte_val = {hum_q[3:0], temp_q[19:16]};
      3'h4: byte_val = temp_q[15:8];
      3'h5: byte_val = temp_q[7:0];
      default: byte_val = crc_bus.crc;
    endcase
  end

  // Expected trigger byte for the current position
  always_comb begin
    unique case (cmd_q)
      2'h0: cmd_exp = CMD_TRIG;
      2'h1: cmd_exp = CMD_P1;
      default: cmd_exp = CMD_P2;
    endcase
  end

  // Next state; data changes only after a falling clock edge
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    tx_d = tx_q;
    idx_d = idx_q;
    cmd_d = cmd_q;
    rd_d = rd_q;
    oe_d = oe_q;
    start_d = 1'b0;
    load = 1'b0;
    load_idx = idx_q;
    if (bus_start) begin
      st_d = HTI_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (bus_stop) begin
      st_d = HTI_IDLE;
      oe_d = 1'b0;
    end else begin
      unique case (st_q)
        HTI_IDLE: begin
        end
        HTI_ADDR: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_s2_q};
            cnt_d = cnt_q + 1'b1;
          end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
            if (sh_q == ADDR_WR || sh_q == ADDR_RD) begin
              oe_d = 1'b1;
              rd_d = sh_q[0];
              st_d = HTI_ACK;
              idx_d = 3'h0;
              cmd_d = 2'h0;
            end else begin
              st_d = HTI_IDLE;
            end
          end
        end
        HTI_ACK: begin
          if (scl_fall) begin
            if (rd_q) begin
              load = 1'b1;
              load_idx = 3'h0;
              oe_d = ~byte_val[7];
              tx_d = {byte_val[6:0], 1'b0};
              cnt_d = 4'h1;
              st_d = HTI_RD;
            end else begin
              oe_d = 1'b0;
              cnt_d = 4'h0;
              st_d = HTI_WR;
            end
          end
        end
        HTI_WR: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_s2_q};
            cnt_d = cnt_q + 1'b1;
          end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
            oe_d = 1'b1;
            st_d = HTI_ACK;
            if (cmd_q != 2'h3) begin
              if (sh_q == cmd_exp) begin
                cmd_d = cmd_q + 1'b1;
                start_d = (cmd_q == 2'h2) && !busy_q;
              end else begin
                cmd_d = 2'h3;
              end
            end
          end
        end
        HTI_RD: begin
          if (scl_fall) begin
            if (cnt_q == BITS_PER_BYTE) begin
              oe_d = 1'b0;
              st_d = HTI_RACK;
            end else begin
              oe_d = ~tx_q[7];
              tx_d = {tx_q[6:0], 1'b0};
              cnt_d = cnt_q + 1'b1;
            end
          end
        end
        HTI_RACK: begin
          if (scl_rise && sda_s2_q) begin
            st_d = HTI_IDLE;
          end else if (scl_fall) begin
            idx_d = (idx_q == FRAME_LAST) ? idx_q : idx_q + 1'b1;
            load = 1'b1;
            load_idx = idx_d;
            oe_d = ~byte_val[7];
            tx_d = {byte_val[6:0], 1'b0};
            cnt_d = 4'h1;
            st_d = HTI_RD;
          end
        end
      endcase
    end
  end

  // Check byte is fed the six data bytes; a fresh read reseeds it
  assign crc_bus.init = load && (load_idx == 3'h0);
  assign crc_bus.en = load && (load_idx < FRAME_LAST) && (load_idx != 3'h0);
  assign crc_bus.data = byte_val;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= HTI_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      idx_q <= 3'h0;
      cmd_q <= 2'h3;
      rd_q <= 1'b0;
      oe_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      idx_q <= idx_d;
      cmd_q <= cmd_d;
      rd_q <= rd_d;
      oe_q <= oe_d;
      start_q <= start_d;
    end
  end

  // Open-drain: only ever pull low
  assign sda_o = 1'b0;
  assign sda_oe = oe_q;
  assign conv_start = start_q;
  assign conv_busy = busy_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_trigger_sets_busy: assert property (@(posedge clk) disable iff (!resetn)
    start_q && !busy_q |=> busy_q [*8]) else $error("busy did not follow trigger");
  a_sleep_holds: assert property (@(posedge clk) disable iff (!resetn)
    !busy_q && !start_q |=> !busy_q) else $error("woke without trigger");
  a_hum_latch: assert property (@(posedge clk) disable iff (!resetn)
    $fell(busy_q) |-> hum_q == $past(humidity_sample)) else $error("humidity not latched");
  a_temp_latch: assert property (@(posedge clk) disable iff (!resetn)
    $fell(busy_q) |-> temp_q == $past(temperature_sample)) else $error("temp not latched");
  a_status_first: assert property (@(posedge clk) disable iff (!resetn)
    load && load_idx == 3'h0 |-> byte_val[7] == busy_q && byte_val[6:5] == work_mode)
    else $error("status byte wrong");
  a_crc_last: assert property (@(posedge clk) disable iff (!resetn)
    load && load_idx == FRAME_LAST |-> byte_val == crc_bus.crc) else $error("crc byte wrong");
  a_shared_byte: assert property (@(posedge clk) disable iff (!resetn)
    load && load_idx == 3'h3 |-> byte_val == {hum_q[3:0], temp_q[19:16]})
    else $error("shared byte wrong");
  a_read_addr_ack: assert property (@(posedge clk) disable iff (!resetn)
    st_q == HTI_ADDR && scl_fall && cnt_q == BITS_PER_BYTE && sh_q == ADDR_RD && !bus_stop
    |=> sda_oe && st_q == HTI_ACK) else $error("read address not acked");
  a_cmd_trigger: assert property (@(posedge clk) disable iff (!resetn)
    st_q == HTI_WR && scl_fall && cnt_q == BITS_PER_BYTE && cmd_q == 2'h2 && sh_q == CMD_P2
    && !busy_q && !bus_start && !bus_stop |=> conv_start ##1 conv_busy)
    else $error("trigger not started");
endmodule // hti_readout
`default_nettype wire

// ---- rtl/hti_pkg.sv ----
// Shared constants for the humidity and temperature readout block
package hti_pkg;
  // Target address bytes as seen on the bus, write and read
  localparam logic [7:0] ADDR_WR = 8'h70;
  localparam logic [7:0] ADDR_RD = 8'h71;
  // Measurement trigger sequence after the write address
  localparam logic [7:0] CMD_TRIG = 8'hac;
  localparam logic [7:0] CMD_P1 = 8'h33;
  localparam logic [7:0] CMD_P2 = 8'h00;
  // Check byte parameters, polynomial x^8+x^5+x^4+1
  localparam logic [7:0] CRC_SEED = 8'hff;
  localparam logic [7:0] CRC_POLY = 8'h31;
  // Status byte layout
  localparam int ST_BUSY_BIT = 7;
  localparam int ST_MODE_HI = 6;
  localparam int ST_MODE_LO = 5;
  localparam logic [4:0] ST_LOW_RESET = 5'h00;
  // Work mode codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_CYCLIC = 2'h1;
  // Frame shape
  localparam int SAMPLE_W = 20;
  localparam logic [2:0] FRAME_LAST = 3'h6;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Conversion time
  localparam int CLK_HZ = 100_000_000;
  localparam int CONV_TIME_MS = 80;
  localparam int CONV_CYCLES = CONV_TIME_MS * (CLK_HZ / 1000);
  localparam int CONV_CNT_W = 23;
  // Bus engine states
  typedef enum logic [2:0] {
    HTI_IDLE, HTI_ADDR, HTI_ACK, HTI_WR, HTI_RD, HTI_RACK
  } hti_state_t;
endpackage

// ---- rtl/hti_crc_if.sv ----
// Carrier between the bus engine and the check byte generator
`timescale 1ns/100ps
`default_nettype none
interface hti_crc_if;
  logic init;
  logic en;
  logic [7:0] data;
  logic [7:0] crc;
  modport calc (input init, input en, input data, output crc);
  modport user (output init, output en, output data, input crc);
endinterface
`default_nettype wire

// ---- rtl/hti_crc8.sv ----
// Byte-wise CRC8 generator for the response frame
`timescale 1ns/100ps
`default_nettype none
module hti_crc8 (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Frame byte stream
  hti_crc_if.calc bus
);
  import hti_pkg::*;

  logic [7:0] crc_q;
  logic [7:0] crc_d;

  // One byte step, MSB first
  function automatic logic [7:0] step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[7] ^ d[i]) begin
        r = {r[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        r = {r[6:0], 1'b0};
      end
    end
    return r;
  endfunction

  // Init restarts from the seed so each read frame stands alone
  always_comb begin
    crc_d = crc_q;
    if (bus.init) begin
      crc_d = step(CRC_SEED, bus.data);
    end else if (bus.en) begin
      crc_d = step(crc_q, bus.data);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crc_q <= CRC_SEED;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign bus.crc = crc_q;
endmodule // hti_crc8
`default_nettype wire

// ---- tb/hti_host_model.sv ----
// Host controller model that drives the two-wire bus toward the sensor
`timescale 1ns/100ps
`default_nettype none
module hti_host_model import hti_pkg::*; (
  // Clock
  input wire logic clk,
  // Bus pins, SCL driven high and low, SDA open drain toward a pull-up
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // SCL stands high outside frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Wait n system cycles; 8 cycles make half of the 160 ns link clock
  task automatic pause(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start();
    pause(8);
    sda_low = 1'b1;
    pause(8);
    scl = 1'b0;
  endtask
  task automatic stop();
    pause(2);
    sda_low = 1'b1;
    pause(6);
    scl = 1'b1;
    pause(8);
    sda_low = 1'b0;
    pause(8);
  endtask
  // Data moves only while SCL is low, with hold after the fall
  task automatic wbit(input logic b);
    pause(2);
    sda_low = ~b;
    pause(6);
    scl = 1'b1;
    pause(8);
    scl = 1'b0;
  endtask
  // Released line reads the pull-up unless the sensor pulls it
  task automatic rbit(output logic b);
    pause(2);
    sda_low = 1'b0;
    pause(6);
    scl = 1'b1;
    pause(4);
    b = sda;
    pause(4);
    scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) wbit(d[i]);
    rbit(a);
    ack = ~a;
  endtask
  // Host acks each byte and leaves the last one unacknowledged
  task automatic rbyte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) rbit(d[i]);
    wbit(last);
  endtask
  // Trigger write, first parameter byte chosen by caller
  task automatic trigger(input logic [7:0] p1, output logic ack);
    logic a0, a1, a2, a3;
    start();
    wbyte(ADDR_WR, a0);
    wbyte(CMD_TRIG, a1);
    wbyte(p1, a2);
    wbyte(CMD_P2, a3);
    stop();
    ack = a0 & a1 & a2 & a3;
  endtask
  // Read address, then the whole seven-byte frame
  task automatic fetch(output logic [7:0] f [7], output logic ack);
    start();
    wbyte(ADDR_RD, ack);
    for (int i = 0; i < 7; i++) rbyte(f[i], i == 6);
    stop();
  endtask
endmodule // hti_host_model
`default_nettype wire

// ---- tb/test_hti_readout.sv ----
// Self-checking bench for the sensor readout block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
  $display("Error %s expected %h seen %h", nm, ex, got); err_total++; end end
module test_hti_readout;
  import hti_pkg::*;
  // Conversion outlasts a whole frame read, so the early read sees only old samples
  localparam int CONV = 1600;
  logic clk, resetn, scl, sda_low, sda, sda_o, sda_oe, conv_start, conv_busy, ack;
  logic [SAMPLE_W-1:0] hum, tmp;
  logic [1:0] mode;
  logic [7:0] fr [7];
  logic [7:0] ex [7];
  int err_total, n_tests, starts, busy_len;
  // Wired-and bus with pull-up
  assign sda = !(sda_low || (sda_oe && !sda_o));
  hti_readout #(.CONV_CYC(CONV)) uut (.clk(clk), .resetn(resetn), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .humidity_sample(hum), .temperature_sample(tmp),
    .work_mode(mode), .conv_start(conv_start), .conv_busy(conv_busy));
  hti_host_model host (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Count trigger pulses and busy length
  always @(posedge clk) begin
    if (conv_start === 1'b1) starts++;
    if (conv_busy === 1'b1) busy_len++;
  end
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Expected frame, check byte worked out bit by bit
  task automatic build(input logic b, input logic [19:0] h, input logic [19:0] t);
    logic [7:0] c;
    ex[0] = {b, mode, 5'h00};
    ex[1] = h[19:12];
    ex[2] = h[11:4];
    ex[3] = {h[3:0], t[19:16]};
    ex[4] = t[15:8];
    ex[5] = t[7:0];
    c = CRC_SEED;
    for (int i = 0; i < 6; i++) begin
      c ^= ex[i];
      for (int k = 0; k < 8; k++) c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    ex[6] = c;
  endtask
  task automatic read_check(input logic b, input logic [19:0] h, input logic [19:0] t);
    build(b, h, t);
    host.fetch(fr, ack);
    `CHK("read_ack", 1'b1, ack)
    `CHK("busy_bit", b, fr[0][7])
    `CHK("mode_bits", mode, fr[0][6:5])
    for (int i = 0; i < 7; i++) `CHK("frame_byte", ex[i], fr[i])
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    conclude();
  end
  initial begin
    resetn = 1'b0;
    hum = '0;
    tmp = '0;
    mode = MODE_NORMAL;
    repeat (10) @(negedge clk);
    `CHK("oe_rst", 1'b0, sda_oe)
    `CHK("busy_rst", 1'b0, conv_busy)
    resetn = 1'b1;
    // Before any conversion the samples read as zero
    read_check(1'b0, 20'h0, 20'h0);
    // Foreign address is refused
    host.start();
    host.wbyte(8'h72, ack);
    host.stop();
    `CHK("bad_addr_ack", 1'b0, ack)
    // Wrong parameter byte must not start a conversion
    host.trigger(8'h34, ack);
    `CHK("bad_trig", 0, starts)
    for (int m = 0; m < 4; m++) begin
      mode = m[1:0];
      hum = 20'h8a5c3 + 20'(m);
      tmp = 20'h2ffab - 20'(m);
      busy_len = 0;
      host.trigger(CMD_P1, ack);
      `CHK("trig_ack", 1'b1, ack)
      `CHK("trig_count", m + 1, starts)
      // Early read sees busy and the previous samples
      if (m == 0) read_check(1'b1, 20'h0, 20'h0);
      for (int i = 0; i < 4000 && conv_busy !== 1'b0; i++) @(negedge clk);
      if (conv_busy !== 1'b0) begin
        err_total++;
        conclude();
      end
      `CHK("busy_len", CONV, busy_len)
      read_check(1'b0, hum, tmp);
    end
    conclude();
  end
endmodule // test_hti_readout
`default_nettype wire
